/* hw/numfmt_pkg.sv */
// Contract
// - Integer operands from a 40-bit register use bits 31..0; bits 39..32 pass unchanged.
// - A 16-bit signed immediate becomes 32 bits by copying its sign bit upward.
// - Signed 32-bit integers are twos complement, range minus 2^31 to 2^31 minus 1.
// - A 16-bit unsigned immediate becomes 32 bits with zeros in the upper half.
// - Unsigned 32-bit integers are plain binary with no sign meaning.
// - Every float has a twos-complement exponent, one sign bit and a fraction.
// - Float value is 01.f times 2^e for sign 0, 10.f for sign 1.
// - A float whose exponent is the most negative code is zero, regardless of other bits.
// - Short float is 4-bit exponent, sign, 11-bit fraction; exponent minus eight means zero.
// - Short float binary point sits between mantissa bits 11 and 10.
// - Single float is 8-bit exponent in 31..24, sign, then 23-bit fraction.
// - Single float binary point sits between mantissa bits 23 and 22.
// - Extended float is exponent 39..32, sign at bit 31, then 31-bit fraction.
// - Extended float binary point sits between mantissa bits 31 and 30.
// - Canonical extended zero is exponent minus 128 with sign and fraction cleared.
// - Format conversions happen inside the operation stage and add no cycles.
// - A narrow zero widened to a wider format becomes that format's reserved zero.
// - Short to single sign-extends exponent, places sign and fraction at 23..12, clears 11..0.
// - Short to extended sign-extends exponent, places sign and fraction at 31..20, clears 19..0.
// - Single to extended copies all fields to 39..8 and clears 7..0.
// - Extended to single keeps exponent, sign, upper fraction, drops eight low bits unrounded.
package numfmt_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int EXT_W = 40;
    localparam int INT_W = 32;
    localparam int HALF_W = 16;
    localparam int EXP_W = 8;
    localparam int SHORT_EXP_W = 4;
    localparam int SHORT_EXP_MSB = 15;
    localparam int SHORT_EXP_LSB = 12;
    localparam int SHORT_SIGN = 11;
    localparam int SHORT_FRAC_MSB = 10;
    localparam int SINGLE_EXP_MSB = 31;
    localparam int SINGLE_EXP_LSB = 24;
    localparam int SINGLE_SIGN = 23;
    localparam int SINGLE_FRAC_MSB = 22;
    localparam int EXT_FRAC_W = 31;
    localparam int SHORT_PAD_W = 20;
    localparam int SINGLE_PAD_W = 8;
    localparam int MAN_W = 33;

    // ----------------------------------------------------------------
    // Reserved values
    // ----------------------------------------------------------------
    localparam logic [EXP_W-1:0] ZERO_EXP = 8'h80;
    localparam logic [SHORT_EXP_W-1:0] SHORT_ZERO_EXP = 4'h8;
    localparam logic [INT_W-1:0] INT_ZERO = 32'h00000000;

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_INT_REG,
        OP_UINT_REG,
        OP_INT_SHORT,
        OP_UINT_SHORT,
        OP_SHORT_TO_SINGLE,
        OP_SHORT_TO_EXT,
        OP_SINGLE_TO_EXT,
        OP_EXT_TO_SINGLE,
        OP_EXT_DECODE
    } op_t;

    typedef struct packed {
        logic [EXP_W-1:0] exp;
        logic sign;
        logic [EXT_FRAC_W-1:0] frac;
    } fp_ext_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic [EXT_W-1:0] operand;
    } req_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [EXT_W-1:0] result;
        logic zero;
        logic negative;
        logic [EXP_W-1:0] exp;
        logic [MAN_W-1:0] man;
    } rsp_t;

endpackage

/* hw/numeric_format_converter.sv */
`timescale 1ns/1ns
`default_nettype none

module numeric_format_converter (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire numfmt_pkg::req_t req,
    output numfmt_pkg::rsp_t rsp
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        numfmt_pkg::rsp_t rsp;
    } state_t;

    state_t state;
    state_t next_state;

    // ----------------------------------------------------------------
    // Integer helpers
    // ----------------------------------------------------------------
    function automatic logic [numfmt_pkg::INT_W-1:0] widen_signed(
        input logic [numfmt_pkg::HALF_W-1:0] imm
    );
        widen_signed = {{numfmt_pkg::HALF_W{imm[numfmt_pkg::HALF_W-1]}}, imm};
    endfunction

    function automatic logic [numfmt_pkg::INT_W-1:0] widen_unsigned(
        input logic [numfmt_pkg::HALF_W-1:0] imm
    );
        widen_unsigned = {{numfmt_pkg::HALF_W{1'b0}}, imm};
    endfunction

    // ----------------------------------------------------------------
    // Float helpers
    // ----------------------------------------------------------------
    // Every layout is lifted to the extended field layout first, so that
    // decoding exists in exactly one place; zeros are caught in from_short, from_single and to_single.
    function automatic numfmt_pkg::fp_ext_t ext_zero();
        numfmt_pkg::fp_ext_t z;
        z.exp = numfmt_pkg::ZERO_EXP;
        z.sign = 1'b0;
        z.frac = '0;
        ext_zero = z;
    endfunction

    function automatic numfmt_pkg::fp_ext_t from_short(
        input logic [numfmt_pkg::HALF_W-1:0] d
    );
        numfmt_pkg::fp_ext_t f;
        logic [numfmt_pkg::SHORT_EXP_W-1:0] e;
        e = d[numfmt_pkg::SHORT_EXP_MSB:numfmt_pkg::SHORT_EXP_LSB];
        f.exp = {{(numfmt_pkg::EXP_W - numfmt_pkg::SHORT_EXP_W){e[numfmt_pkg::SHORT_EXP_W-1]}}, e};
        f.sign = d[numfmt_pkg::SHORT_SIGN];
        f.frac = {d[numfmt_pkg::SHORT_FRAC_MSB:0], {numfmt_pkg::SHORT_PAD_W{1'b0}}};
        if (e == numfmt_pkg::SHORT_ZERO_EXP) begin
            // Plain sign extension would give exponent minus eight, which is
            // not zero in the wider layouts.
            f = ext_zero();
        end
        from_short = f;
    endfunction

    function automatic numfmt_pkg::fp_ext_t from_single(
        input logic [numfmt_pkg::INT_W-1:0] d
    );
        numfmt_pkg::fp_ext_t f;
        f.exp = d[numfmt_pkg::SINGLE_EXP_MSB:numfmt_pkg::SINGLE_EXP_LSB];
        f.sign = d[numfmt_pkg::SINGLE_SIGN];
        f.frac = {d[numfmt_pkg::SINGLE_FRAC_MSB:0], {numfmt_pkg::SINGLE_PAD_W{1'b0}}};
        if (f.exp == numfmt_pkg::ZERO_EXP) begin
            f = ext_zero();
        end
        from_single = f;
    endfunction

    function automatic logic [numfmt_pkg::INT_W-1:0] to_single(
        input numfmt_pkg::fp_ext_t f
    );
        numfmt_pkg::fp_ext_t g;
        g = f;
        if (f.exp == numfmt_pkg::ZERO_EXP) begin
            g = ext_zero();
        end
        // Low fraction bits are dropped, never rounded.
        to_single = {g.exp, g.sign,
                     g.frac[numfmt_pkg::EXT_FRAC_W-1:numfmt_pkg::SINGLE_PAD_W]};
    endfunction

    function automatic logic is_zero(
        input numfmt_pkg::fp_ext_t f
    );
        is_zero = (f.exp == numfmt_pkg::ZERO_EXP);
    endfunction

    // Mantissa with the nonsign bit made explicit: sign, nonsign, fraction.
    // The binary point lies below the nonsign bit, which is bit 31 of this
    // word; short and single sit in its upper bits with their own points
    // between 11 and 10 and between 23 and 22 of their mantissas.
    function automatic logic [numfmt_pkg::MAN_W-1:0] explicit_man(
        input numfmt_pkg::fp_ext_t f
    );
        if (is_zero(f)) begin
            explicit_man = '0;
        end else begin
            explicit_man = {f.sign, ~f.sign, f.frac};
        end
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // The whole conversion is combinational inside one stage, so an
    // arithmetic unit that fuses it into its own stage pays no cycle.
    always_comb begin
        numfmt_pkg::fp_ext_t src;
        logic [numfmt_pkg::INT_W-1:0] word;
        logic float_op;
        src = ext_zero();
        word = numfmt_pkg::INT_ZERO;
        float_op = 1'b0;
        next_state = state;
        if (ce) begin
            next_state.rst_meta = 1'b1;
            next_state.rst_sync = state.rst_meta;
            next_state.rsp = '0;
            next_state.rsp.valid = req.valid;
            if (req.valid) begin
                unique case (req.op)
                    numfmt_pkg::OP_INT_REG: begin
                        word = req.operand[numfmt_pkg::INT_W-1:0];
                        next_state.rsp.result = req.operand;
                        next_state.rsp.negative = word[numfmt_pkg::INT_W-1];
                        next_state.rsp.zero = (word == numfmt_pkg::INT_ZERO);
                    end
                    numfmt_pkg::OP_UINT_REG: begin
                        word = req.operand[numfmt_pkg::INT_W-1:0];
                        next_state.rsp.result = req.operand;
                        next_state.rsp.negative = 1'b0;
                        next_state.rsp.zero = (word == numfmt_pkg::INT_ZERO);
                    end
                    numfmt_pkg::OP_INT_SHORT: begin
                        word = widen_signed(req.operand[numfmt_pkg::HALF_W-1:0]);
                        next_state.rsp.result = {{(numfmt_pkg::EXT_W - numfmt_pkg::INT_W){1'b0}}, word};
                        next_state.rsp.negative = word[numfmt_pkg::INT_W-1];
                        next_state.rsp.zero = (word == numfmt_pkg::INT_ZERO);
                    end
                    numfmt_pkg::OP_UINT_SHORT: begin
                        word = widen_unsigned(req.operand[numfmt_pkg::HALF_W-1:0]);
                        next_state.rsp.result = {{(numfmt_pkg::EXT_W - numfmt_pkg::INT_W){1'b0}}, word};
                        next_state.rsp.negative = 1'b0;
                        next_state.rsp.zero = (word == numfmt_pkg::INT_ZERO);
                    end
                    numfmt_pkg::OP_SHORT_TO_SINGLE: begin
                        float_op = 1'b1;
                        src = from_short(req.operand[numfmt_pkg::HALF_W-1:0]);
                        word = to_single(src);
                        next_state.rsp.result = {{(numfmt_pkg::EXT_W - numfmt_pkg::INT_W){1'b0}}, word};
                    end
                    numfmt_pkg::OP_SHORT_TO_EXT: begin
                        float_op = 1'b1;
                        src = from_short(req.operand[numfmt_pkg::HALF_W-1:0]);
                        next_state.rsp.result = src;
                    end
                    numfmt_pkg::OP_SINGLE_TO_EXT: begin
                        float_op = 1'b1;
                        src = from_single(req.operand[numfmt_pkg::INT_W-1:0]);
                        next_state.rsp.result = src;
                    end
                    numfmt_pkg::OP_EXT_TO_SINGLE: begin
                        float_op = 1'b1;
                        src = req.operand;
                        word = to_single(src);
                        src = from_single(word);
                        next_state.rsp.result = {{(numfmt_pkg::EXT_W - numfmt_pkg::INT_W){1'b0}}, word};
                    end
                    numfmt_pkg::OP_EXT_DECODE: begin
                        float_op = 1'b1;
                        src = req.operand;
                        // The stored word is kept as given; only the decode
                        // treats a non-canonical zero as zero.
                        next_state.rsp.result = req.operand;
                    end
                    default: begin
                        next_state.rsp.illegal = 1'b1;
                    end
                endcase
                if (float_op) begin
                    next_state.rsp.zero = is_zero(src);
                    next_state.rsp.negative = src.sign & ~is_zero(src);
                    next_state.rsp.exp = is_zero(src) ? numfmt_pkg::ZERO_EXP : src.exp;
                    next_state.rsp.man = explicit_man(src);
                end
            end
            if (!state.rst_sync) begin
                next_state.rsp = '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // The reset release passes two flops inside the state word; until the
    // second one is set the answer register is held clear.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rsp = state.rsp;

endmodule

`default_nettype wire

/* verification/numeric_format_converter_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module numeric_format_converter_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire numfmt_pkg::req_t req,
    input wire numfmt_pkg::rsp_t rsp
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    // Requests are only taken once the reset synchroniser has seen two ce edges.
    logic [1:0] warm;
    logic live;
    numfmt_pkg::req_t last;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            warm <= 2'h0;
        end else if (ce && warm != 2'h2) begin
            warm <= warm + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        last <= req;
    end

    assign live = (warm == 2'h2);

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_take(numfmt_pkg::op_t o);
        live && ce && req.valid && req.op == o;
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_answer_next: assert property (live && ce && req.valid |=> rsp.valid)
        else $error("request not answered on the next cycle");
    a_idle_clear: assert property (ce && !req.valid |=> rsp == '0)
        else $error("response not cleared without a request");
    a_hold_frozen: assert property (!ce |=> $stable(rsp))
        else $error("response changed while clock enable was low");
    a_reg_kept: assert property (s_take(numfmt_pkg::OP_INT_REG) |=> rsp.result == last.operand)
        else $error("register integer operand altered");
    a_sign_extend: assert property (s_take(numfmt_pkg::OP_INT_SHORT)
        |=> rsp.result == {8'h00, {16{last.operand[15]}}, last.operand[15:0]})
        else $error("short signed immediate not sign extended");
    a_zero_fill: assert property (s_take(numfmt_pkg::OP_UINT_SHORT)
        |=> rsp.result == {24'h000000, last.operand[15:0]})
        else $error("short unsigned immediate not zero filled");
    a_short_single: assert property (s_take(numfmt_pkg::OP_SHORT_TO_SINGLE)
        ##0 req.operand[15:12] != 4'h8
        |=> rsp.result == {8'h00, {4{last.operand[15]}}, last.operand[15:0], 12'h000})
        else $error("short to single layout wrong");
    a_short_ext: assert property (s_take(numfmt_pkg::OP_SHORT_TO_EXT)
        ##0 req.operand[15:12] != 4'h8
        |=> rsp.result == {{4{last.operand[15]}}, last.operand[15:0], 20'h00000})
        else $error("short to extended layout wrong");
    a_short_zero: assert property (s_take(numfmt_pkg::OP_SHORT_TO_EXT)
        ##0 req.operand[15:12] == 4'h8
        |=> rsp.result == 40'h8000000000 && rsp.zero && rsp.man == '0)
        else $error("short zero not widened to reserved zero");
    a_single_ext: assert property (s_take(numfmt_pkg::OP_SINGLE_TO_EXT)
        ##0 req.operand[31:24] != 8'h80
        |=> rsp.result == {last.operand[31:0], 8'h00}
        && rsp.man == {last.operand[23], ~last.operand[23], last.operand[22:0], 8'h00})
        else $error("single to extended layout wrong");
    a_ext_single: assert property (s_take(numfmt_pkg::OP_EXT_TO_SINGLE)
        ##0 req.operand[39:32] != 8'h80
        |=> rsp.result == {8'h00, last.operand[39:8]})
        else $error("extended to single not truncated");
    a_ext_zero: assert property (s_take(numfmt_pkg::OP_EXT_TO_SINGLE)
        ##0 req.operand[39:32] == 8'h80
        |=> rsp.result == 40'h0080000000 && rsp.zero && !rsp.negative)
        else $error("extended zero not recognised");
endmodule

bind numeric_format_converter numeric_format_converter_monitor mon (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .req(req),
    .rsp(rsp)
);

`default_nettype wire

/* verification/numeric_format_converter_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module numeric_format_converter_tb;
    logic mclk;
    logic nrst;
    logic ce;
    numfmt_pkg::req_t req;
    numfmt_pkg::rsp_t rsp;
    numfmt_pkg::rsp_t expct;
    int warm;
    int checked;
    int n_mismatch;

    numeric_format_converter dut (.mclk(mclk), .nrst(nrst), .ce(ce), .req(req), .rsp(rsp));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic numfmt_pkg::rsp_t model(numfmt_pkg::req_t r);
        numfmt_pkg::rsp_t s;
        logic [39:0] d;
        logic [7:0] e;
        logic sg;
        logic z;
        logic [30:0] f;
        s = '0;
        d = r.operand;
        if (!r.valid) return s;
        s.valid = 1'b1;
        case (r.op)
            numfmt_pkg::OP_INT_SHORT: s.result = {8'h00, {16{d[15]}}, d[15:0]};
            numfmt_pkg::OP_UINT_SHORT: s.result = {24'h000000, d[15:0]};
            numfmt_pkg::OP_INT_REG, numfmt_pkg::OP_UINT_REG, numfmt_pkg::OP_EXT_DECODE: s.result = d;
            default: s.result = '0;
        endcase
        if (r.op <= numfmt_pkg::OP_UINT_SHORT) begin
            s.zero = (s.result[31:0] == 32'h00000000);
            s.negative = s.result[31] && (r.op == numfmt_pkg::OP_INT_REG || r.op == numfmt_pkg::OP_INT_SHORT);
            return s;
        end
        if (r.op > numfmt_pkg::OP_EXT_DECODE) begin
            s.illegal = 1'b1;
            s.result = '0;
            return s;
        end
        if (r.op <= numfmt_pkg::OP_SHORT_TO_EXT) begin
            e = {{4{d[15]}}, d[15:12]};
            z = (d[15:12] == 4'h8);
            sg = d[11];
            f = {d[10:0], 20'h00000};
        end else if (r.op == numfmt_pkg::OP_SINGLE_TO_EXT) begin
            e = d[31:24];
            z = (e == 8'h80);
            sg = d[23];
            f = {d[22:0], 8'h00};
        end else begin
            e = d[39:32];
            z = (e == 8'h80);
            sg = d[31];
            // The narrowed word is what gets decoded, so its dropped bits read as zero.
            f = (r.op == numfmt_pkg::OP_EXT_TO_SINGLE) ? {d[30:8], 8'h00} : d[30:0];
        end
        // Every zero leaves in the canonical form, whatever sign and fraction it carried, except an OP_EXT_DECODE result, which keeps the operand.
        if (z) begin
            e = 8'h80;
            sg = 1'b0;
            f = '0;
        end
        s.zero = z;
        s.negative = sg;
        s.exp = e;
        s.man = z ? '0 : {sg, ~sg, f};
        if (r.op == numfmt_pkg::OP_SHORT_TO_SINGLE || r.op == numfmt_pkg::OP_EXT_TO_SINGLE) begin
            s.result = {8'h00, e, sg, f[30:8]};
        end else if (r.op != numfmt_pkg::OP_EXT_DECODE) begin
            s.result = {e, sg, f};
        end
        return s;
    endfunction

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            expct <= '0;
            warm <= 0;
        end else if (ce) begin
            warm <= (warm < 2) ? warm + 1 : warm;
            expct <= (warm < 2) ? '0 : model(req);
        end
    end

    always @(negedge mclk) begin
        if (nrst) `CHK(rsp, expct)
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic issue(numfmt_pkg::op_t o, logic [39:0] d);
        @(negedge mclk);
        ce <= 1'b1;
        req.valid <= 1'b1;
        req.op <= o;
        req.operand <= d;
        @(posedge mclk);
        #1;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        req = '0;
        checked = 0;
        n_mismatch = 0;
        void'($urandom(74));
        repeat (4) @(negedge mclk);
        nrst <= 1'b1;
        repeat (2) @(negedge mclk);
        issue(numfmt_pkg::OP_INT_REG, 40'hA580000001);
        `CHK(rsp.result, 40'hA580000001)
        `CHK(rsp.negative, 1'b1)
        issue(numfmt_pkg::OP_UINT_REG, 40'h5A80000000);
        `CHK(rsp.negative, 1'b0)
        issue(numfmt_pkg::OP_INT_SHORT, 40'h0000008000);
        `CHK(rsp.result, 40'h00FFFF8000)
        issue(numfmt_pkg::OP_UINT_SHORT, 40'h0000008000);
        `CHK(rsp.result, 40'h0000008000)
        $display("test integer done");
        issue(numfmt_pkg::OP_SHORT_TO_EXT, 40'h0000001400);
        `CHK(rsp.result, 40'h0140000000)
        `CHK(rsp.man, {2'b01, 31'h40000000})
        issue(numfmt_pkg::OP_SHORT_TO_SINGLE, 40'h000000F9FF);
        `CHK(rsp.result, 40'h00FF9FF000)
        `CHK(rsp.man, {2'b10, 11'h1FF, 20'h00000})
        issue(numfmt_pkg::OP_SHORT_TO_SINGLE, 40'h0000008FFF);
        `CHK(rsp.result, 40'h0080000000)
        issue(numfmt_pkg::OP_SINGLE_TO_EXT, 40'h007FFFFFFF);
        `CHK(rsp.result, 40'h7FFFFFFF00)
        issue(numfmt_pkg::OP_EXT_TO_SINGLE, 40'h05123456FF);
        `CHK(rsp.result, 40'h0005123456)
        issue(numfmt_pkg::OP_EXT_DECODE, 40'h80FFFFFFFF);
        `CHK({rsp.zero, rsp.man}, {1'b1, 33'h0})
        issue(numfmt_pkg::OP_SINGLE_TO_EXT, 40'h0080ABCDEF);
        `CHK(rsp.result, 40'h8000000000)
        $display("test float done");
        repeat (3000) begin
            @(negedge mclk);
            ce <= ($urandom % 8) != 0;
            req.valid <= ($urandom % 4) != 0;
            req.op <= numfmt_pkg::op_t'(4'($urandom));
            req.operand <= {8'($urandom), $urandom};
        end
        $display("test random done");
        @(negedge mclk);
        nrst <= 1'b0;
        ce <= 1'b1;
        repeat (2) @(negedge mclk);
        nrst <= 1'b1;
        repeat (6) @(negedge mclk);
        $display("test reset done");
        complete_run();
    end
endmodule

`default_nettype wire
